// File: rtl/lag_pkg.sv
// Package with register map, reset values and timing units of the left AGC config core
package lag_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int LAG_ADDR_W = 12;
  localparam logic [7:0] LAG_IDX_ENABLE = 8'h56;
  localparam logic [7:0] LAG_IDX_MAX_GAIN = 8'h58;
  localparam logic [7:0] LAG_IDX_ATTACK = 8'h59;
  localparam logic [7:0] LAG_IDX_DECAY = 8'h5A;
  localparam logic [7:0] LAG_IDX_NOISE = 8'h5B;
  localparam logic [7:0] LAG_IDX_STATUS = 8'h60;
  localparam logic [1:0] LAG_RESP_OKAY = 2'h0;
  localparam logic [1:0] LAG_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int LAG_ENABLE_BIT = 7;
  localparam int LAG_TIME_SHIFT = 3;
  localparam logic [6:0] LAG_MAX_GAIN_RST = 7'h7F;
  localparam logic [7:0] LAG_ATTACK_RST = 8'h00;
  localparam logic [7:0] LAG_DECAY_RST = 8'h00;
  localparam logic [4:0] LAG_NOISE_RST = 5'h00;
  localparam logic [6:0] LAG_GAIN_CEIL_TOP = 7'h74;

  // ****************************************************************
  // Timing units in ADC word clocks
  // ****************************************************************
  localparam int LAG_CNT_W = 23;
  localparam int LAG_ATTACK_UNIT = 32;
  localparam int LAG_DECAY_UNIT = 512;
  localparam int LAG_NOISE_UNIT = 4096;
  localparam logic [4:0] LAG_NOISE_LIN_START = 5'h0C;
  localparam logic [4:0] LAG_NOISE_LIN_TOP = 5'h1E;
  localparam logic [4:0] LAG_NOISE_LIN_BASE = 5'h0A;

  // Index of a register to its byte address
  function automatic logic [LAG_ADDR_W-1:0] lag_addr(input logic [7:0] idx);
    lag_addr = {2'h0, idx, 2'h0};
  endfunction

endpackage : lag_pkg

// File: rtl/lag_hold_timer.sv
// Hold timer that expires after a programmed number of run cycles
`timescale 1ns/1ps
module lag_hold_timer
  import lag_pkg::*;
#(
  parameter int CW = LAG_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic restart,
  input wire logic [CW-1:0] target,
  output logic expired
);

  // ****************************************************************
  // Counter
  // ****************************************************************
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic [CW:0] count_plus;

  // A target of zero expires on the first run cycle
  assign count_plus = {1'b0, count_reg} + {{CW{1'b0}}, 1'b1};
  assign expired = run && (count_plus >= {1'b0, target});

  // Clear when idle, saturate or restart on expiry
  always_comb begin
    if (!run) begin
      count_next = '0;
    end else if (expired) begin
      count_next = restart ? '0 : count_reg;
    end else begin
      count_next = count_plus[CW-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule // lag_hold_timer

// File: rtl/lag_config_core.sv
// Left AGC gain limit and timing configuration core with AXI4-Lite registers
//
// Contract
// - Gain code is ceiling in half dB
// - Codes 117 to 127 clamp to 58 dB
// - Attack base is (2N+1) times 32 clocks
// - Attack base scaled by two to k
// - Decay base is (2N+1) times 512 clocks
// - Decay base scaled by two to k
// - Noise codes 1-11 doubling, none at 1; here codes 2-9 give 2^code clocks and 10-11 give 2^(code+1)
// - Noise codes 12-30 are (code-10)*4096
// - Noise code 31 equals code 30
// - Reserved top bits read zero, write default
// - Settings act only while enable set; here only the timers are gated, gain_ceiling ignores enable
`timescale 1ns/1ps
module lag_config_core
  import lag_pkg::*;
#(
  parameter int ATTACK_UNIT = LAG_ATTACK_UNIT,
  parameter int DECAY_UNIT = LAG_DECAY_UNIT,
  parameter int NOISE_UNIT = LAG_NOISE_UNIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [LAG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [LAG_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Gain loop side
  input wire logic noise_below,
  output logic agc_enable,
  output logic [6:0] gain_ceiling,
  output logic [LAG_CNT_W-1:0] attack_count,
  output logic [LAG_CNT_W-1:0] decay_count,
  output logic [LAG_CNT_W-1:0] noise_count,
  output logic attack_tick,
  output logic decay_tick,
  output logic noise_hold
);
  // ****************************************************************
  // Code conversion functions
  // ****************************************************************
  // ceiling from code
  function automatic logic [6:0] ceil_of(input logic [6:0] code);
    ceil_of = (code > LAG_GAIN_CEIL_TOP) ? LAG_GAIN_CEIL_TOP : code;
  endfunction

  // Odd multiple of unit shifted by scale; used for attack and decay
  function automatic logic [LAG_CNT_W-1:0] interval_of(input logic [7:0] code,
                                                      input int unit);
    logic [LAG_CNT_W-1:0] odd;
    logic [LAG_CNT_W-1:0] base;
    odd = {{(LAG_CNT_W-6){1'b0}}, code[7:3], 1'b1};
    base = LAG_CNT_W'(odd * LAG_CNT_W'(unit));
    interval_of = base << code[2:0];
  endfunction

  // Noise debounce length from code
  function automatic logic [LAG_CNT_W-1:0] noise_of(input logic [4:0] code,
                                                   input int unit);
    logic [4:0] lin;
    logic [4:0] mult;
    lin = (code > LAG_NOISE_LIN_TOP) ? LAG_NOISE_LIN_TOP : code;
    mult = lin - LAG_NOISE_LIN_BASE;
    if (code <= 5'h01) begin
      noise_of = '0;
    end else if (code <= 5'h09) begin
      noise_of = LAG_CNT_W'(1) << code;
    end else if (code < LAG_NOISE_LIN_START) begin
      noise_of = LAG_CNT_W'(1) << (code + 5'h01);
    end else begin
      noise_of = LAG_CNT_W'({{(LAG_CNT_W-5){1'b0}}, mult} * LAG_CNT_W'(unit));
    end
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic enable_reg;
  logic [6:0] max_gain_reg;
  logic [7:0] attack_reg;
  logic [7:0] decay_reg;
  logic [4:0] noise_reg;

  logic aw_have_reg;
  logic [LAG_ADDR_W-1:0] aw_addr_reg;
  logic w_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  // ****************************************************************
  // Channel handshakes and write path
  // ****************************************************************
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire b_fire = s_axi_bvalid && s_axi_bready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire r_fire = s_axi_rvalid && s_axi_rready;

  // One write in flight; address and data taken in either order
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  wire do_write = aw_have_reg && w_have_reg && !bvalid_reg;

  // Write address decode
  wire wsel_enable = aw_addr_reg == lag_addr(LAG_IDX_ENABLE);
  wire wsel_gain = aw_addr_reg == lag_addr(LAG_IDX_MAX_GAIN);
  wire wsel_attack = aw_addr_reg == lag_addr(LAG_IDX_ATTACK);
  wire wsel_decay = aw_addr_reg == lag_addr(LAG_IDX_DECAY);
  wire wsel_noise = aw_addr_reg == lag_addr(LAG_IDX_NOISE);
  wire wsel_status = aw_addr_reg == lag_addr(LAG_IDX_STATUS);
  wire wsel_hit = wsel_enable || wsel_gain || wsel_attack || wsel_decay ||
                  wsel_noise || wsel_status;
  // Only the low lane carries register bits
  wire wlane0 = do_write && w_strb_reg[0];

  // Capture address and data separately
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (aw_fire) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[LAG_ADDR_W-1:2], 2'h0};
    end else if (do_write) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (w_fire) begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_reg <= 1'b0;
    end
  end

  // Response; status is read only, so a write there is refused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= LAG_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wsel_hit && !wsel_status) ? LAG_RESP_OKAY : LAG_RESP_SLVERR;
    end else if (b_fire) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // reserved bits are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg <= 1'b0;
      max_gain_reg <= LAG_MAX_GAIN_RST;
      attack_reg <= LAG_ATTACK_RST;
      decay_reg <= LAG_DECAY_RST;
      noise_reg <= LAG_NOISE_RST;
    end else if (wlane0) begin
      if (wsel_enable) begin
        enable_reg <= w_data_reg[LAG_ENABLE_BIT];
      end
      if (wsel_gain) begin
        max_gain_reg <= w_data_reg[6:0];
      end
      if (wsel_attack) begin
        attack_reg <= w_data_reg[7:0];
      end
      if (wsel_decay) begin
        decay_reg <= w_data_reg[7:0];
      end
      if (wsel_noise) begin
        noise_reg <= w_data_reg[4:0];
      end
    end
  end

  // ****************************************************************
  // Derived limits and counts
  // ****************************************************************
  logic [6:0] ceiling_reg;
  logic [LAG_CNT_W-1:0] attack_cnt_reg;
  logic [LAG_CNT_W-1:0] decay_cnt_reg;
  logic [LAG_CNT_W-1:0] noise_cnt_reg;

  // Registered so the loop sees a change one cycle after the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ceiling_reg <= ceil_of(LAG_MAX_GAIN_RST);
      attack_cnt_reg <= '0;
      decay_cnt_reg <= '0;
      noise_cnt_reg <= '0;
    end else begin
      ceiling_reg <= ceil_of(max_gain_reg);
      attack_cnt_reg <= interval_of(attack_reg, ATTACK_UNIT);
      decay_cnt_reg <= interval_of(decay_reg, DECAY_UNIT);
      noise_cnt_reg <= noise_of(noise_reg, NOISE_UNIT);
    end
  end

  assign gain_ceiling = ceiling_reg;
  assign attack_count = attack_cnt_reg;
  assign decay_count = decay_cnt_reg;
  assign noise_count = noise_cnt_reg;
  assign agc_enable = enable_reg;

  // ****************************************************************
  // Step timers
  // ****************************************************************
  logic attack_exp;
  logic decay_exp;
  logic noise_exp;
  logic attack_tick_reg;
  logic decay_tick_reg;
  logic noise_hold_reg;

  wire run_steps = enable_reg;
  wire run_noise = enable_reg && noise_below;

  // Periodic attack step
  lag_hold_timer #(
    .CW(LAG_CNT_W)
  ) u_attack (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run_steps),
    .restart(1'b1),
    .target(attack_cnt_reg),
    .expired(attack_exp)
  );

  // Periodic decay step
  lag_hold_timer #(
    .CW(LAG_CNT_W)
  ) u_decay (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run_steps),
    .restart(1'b1),
    .target(decay_cnt_reg),
    .expired(decay_exp)
  );

  // Noise must persist the debounce length before the hold asserts
  lag_hold_timer #(
    .CW(LAG_CNT_W)
  ) u_noise (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run_noise),
    .restart(1'b0),
    .target(noise_cnt_reg),
    .expired(noise_exp)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      attack_tick_reg <= 1'b0;
      decay_tick_reg <= 1'b0;
      noise_hold_reg <= 1'b0;
    end else begin
      attack_tick_reg <= attack_exp;
      decay_tick_reg <= decay_exp;
      noise_hold_reg <= noise_exp;
    end
  end

  assign attack_tick = attack_tick_reg;
  assign decay_tick = decay_tick_reg;
  assign noise_hold = noise_hold_reg;

  // ****************************************************************
  // Read channel
  // ****************************************************************
  // One read in flight; next address taken once data is gone
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  wire [LAG_ADDR_W-1:0] raddr = {s_axi_araddr[LAG_ADDR_W-1:2], 2'h0};
  wire rsel_enable = raddr == lag_addr(LAG_IDX_ENABLE);
  wire rsel_gain = raddr == lag_addr(LAG_IDX_MAX_GAIN);
  wire rsel_attack = raddr == lag_addr(LAG_IDX_ATTACK);
  wire rsel_decay = raddr == lag_addr(LAG_IDX_DECAY);
  wire rsel_noise = raddr == lag_addr(LAG_IDX_NOISE);
  wire rsel_status = raddr == lag_addr(LAG_IDX_STATUS);
  wire rsel_hit = rsel_enable || rsel_gain || rsel_attack || rsel_decay ||
                  rsel_noise || rsel_status;

  wire [31:0] status_word = {17'h00000, ceiling_reg, 5'h00, noise_hold_reg,
                             enable_reg, enable_reg};
  wire [31:0] rmux =
    rsel_enable ? {24'h000000, enable_reg, 7'h00} :
    rsel_gain ? {25'h0000000, max_gain_reg} :
    rsel_attack ? {24'h000000, attack_reg} :
    rsel_decay ? {24'h000000, decay_reg} :
    rsel_noise ? {27'h0000000, noise_reg} :
    rsel_status ? status_word : 32'h00000000;

  // Unmapped reads answer zero with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= LAG_RESP_OKAY;
      rdata_reg <= '0;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rsel_hit ? LAG_RESP_OKAY : LAG_RESP_SLVERR;
      rdata_reg <= rmux;
    end else if (r_fire) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Protection bits carry no meaning here
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot, w_data_reg[31:8], w_strb_reg[3:1]};
endmodule // lag_config_core

// File: tb/lag_config_props.sv
// Concurrent checks on the left AGC configuration core outputs
`timescale 1ns/1ps
module lag_config_props
  import lag_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic noise_below,
  input wire logic agc_enable,
  input wire logic [6:0] gain_ceiling,
  input wire logic [LAG_CNT_W-1:0] attack_count,
  input wire logic [LAG_CNT_W-1:0] decay_count,
  input wire logic [LAG_CNT_W-1:0] noise_count,
  input wire logic attack_tick,
  input wire logic decay_tick,
  input wire logic noise_hold
);
  // ****************
  // Helper counters
  // ****************
  logic [LAG_CNT_W:0] gap_a_reg, gap_d_reg, run_reg;
  logic [LAG_CNT_W-1:0] cnt_a_reg, cnt_d_reg;
  logic val_a_reg, val_d_reg;

  // Cycles since the last tick
  always_ff @(posedge aclk) begin
    gap_a_reg <= attack_tick ? 24'h1 : gap_a_reg + 24'h1;
    gap_d_reg <= decay_tick ? 24'h1 : gap_d_reg + 24'h1;
    cnt_a_reg <= attack_count;
    cnt_d_reg <= decay_count;
  end

  // Gap trusted only over an enabled span with a steady count
  always_ff @(posedge aclk) begin
    if (!aresetn || !agc_enable || attack_count != cnt_a_reg) val_a_reg <= 1'b0;
    else if (attack_tick) val_a_reg <= 1'b1;
    if (!aresetn || !agc_enable || decay_count != cnt_d_reg) val_d_reg <= 1'b0;
    else if (decay_tick) val_d_reg <= 1'b1;
    if (!aresetn || !(noise_below && agc_enable)) run_reg <= '0;
    else run_reg <= run_reg + 24'h1;
  end

  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Two sampled cycles with the function off
  sequence s_off_two;
    !agc_enable ##1 !agc_enable;
  endsequence

  a_ceil_limit: assert property (gain_ceiling <= 7'h74)
    else $error("ceiling above top code");
  a_reset_vals: assert property ($rose(aresetn) |-> gain_ceiling == 7'h74 && !agc_enable)
    else $error("wrong values at reset release");
  a_off_quiet: assert property (s_off_two |-> !attack_tick && !decay_tick && !noise_hold)
    else $error("timing output while disabled");
  a_attack_pulse: assert property (attack_tick |=> !attack_tick)
    else $error("attack tick longer than one cycle");
  a_decay_pulse: assert property (decay_tick |=> !decay_tick)
    else $error("decay tick longer than one cycle");
  a_attack_gap: assert property (attack_tick && val_a_reg |-> gap_a_reg == {1'b0, attack_count})
    else $error("attack tick period differs from count");
  a_decay_gap: assert property (decay_tick && val_d_reg |-> gap_d_reg == {1'b0, decay_count})
    else $error("decay tick period differs from count");
  a_attack_form: assert property (aresetn && $past(aresetn) |-> attack_count[4:0] == 5'h0 && attack_count != '0)
    else $error("attack count not a whole unit multiple");
  a_noise_top: assert property (noise_count <= 23'h14000)
    else $error("debounce above top value");
  a_hold_wait: assert property ($rose(noise_hold) |-> run_reg >= {1'b0, noise_count})
    else $error("hold rose before debounce ran out");
endmodule // lag_config_props

bind lag_config_core lag_config_props u_props (
  .aclk(aclk),
  .aresetn(aresetn),
  .noise_below(noise_below),
  .agc_enable(agc_enable),
  .gain_ceiling(gain_ceiling),
  .attack_count(attack_count),
  .decay_count(decay_count),
  .noise_count(noise_count),
  .attack_tick(attack_tick),
  .decay_tick(decay_tick),
  .noise_hold(noise_hold)
);

// File: tb/tb_lag_config_core.sv
// Self-checking bench for the left AGC gain limit and timing core
`timescale 1ns/1ps
module tb_lag_config_core
  import lag_pkg::*;
;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
  } lag_tb_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [LAG_ADDR_W-1:0] s_axi_awaddr = '0;
  logic [LAG_ADDR_W-1:0] s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic noise_below = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd, gap;
  logic agc_enable, attack_tick, decay_tick, noise_hold;
  logic [6:0] gain_ceiling;
  logic [LAG_CNT_W-1:0] attack_count, decay_count, noise_count;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  // Register code, value written, value read back
  lag_tb_row_t rows [22] = '{'{8'h58, 8'h00, 8'h00}, '{8'h58, 8'h01, 8'h01},
    '{8'h58, 8'h74, 8'h74}, '{8'h58, 8'h75, 8'h75}, '{8'h58, 8'hFF, 8'h7F},
    '{8'h59, 8'h00, 8'h00}, '{8'h59, 8'h09, 8'h09}, '{8'h59, 8'hFF, 8'hFF},
    '{8'h59, 8'hF5, 8'hF5}, '{8'h5A, 8'h00, 8'h00}, '{8'h5A, 8'h12, 8'h12},
    '{8'h5A, 8'hFF, 8'hFF}, '{8'h5B, 8'h00, 8'h00}, '{8'h5B, 8'h01, 8'h01},
    '{8'h5B, 8'h02, 8'h02}, '{8'h5B, 8'h03, 8'h03}, '{8'h5B, 8'h0A, 8'h0A},
    '{8'h5B, 8'h0B, 8'h0B}, '{8'h5B, 8'h0C, 8'h0C}, '{8'h5B, 8'h1E, 8'h1E},
    '{8'h5B, 8'h1F, 8'h1F}, '{8'h5B, 8'hFF, 8'h1F}};
  lag_tb_row_t rst [4] = '{'{8'h58, 8'h7F, 8'h7F}, '{8'h59, 8'h00, 8'h00},
    '{8'h5A, 8'h00, 8'h00}, '{8'h5B, 8'h00, 8'h00}};

  // 20 MHz clock
  always #25 aclk = ~aclk;

  lag_config_core dut (.*);

  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid;
      r = s_axi_bresp;
    end
  endtask

  task automatic axi_read(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
  endtask

  // Cycles until the next tick, capped when none comes
  task automatic tick_gap(input logic sel, output logic [31:0] n);
    n = 32'h0;
    do begin
      @(posedge aclk);
      n++;
    end while ((sel ? decay_tick : attack_tick) !== 1'b1 && n < 32'h7D0);
  endtask

  function automatic logic [31:0] out_now(input logic [7:0] idx);
    case (idx)
      8'h58: out_now = {25'h0, gain_ceiling};
      8'h59: out_now = {9'h0, attack_count};
      8'h5A: out_now = {9'h0, decay_count};
      default: out_now = {9'h0, noise_count};
    endcase
  endfunction

  // Expected derived value of a code
  function automatic logic [31:0] model(input logic [7:0] idx, input logic [7:0] c);
    logic [31:0] n;
    n = {27'h0, c[7:3]};
    model = 32'h0;
    case (idx)
      8'h58: model = (c[6:0] > 7'h74) ? 32'h74 : {25'h0, c[6:0]};
      8'h59: model = ((32'h2 * n + 32'h1) * LAG_ATTACK_UNIT) << c[2:0];
      8'h5A: model = ((32'h2 * n + 32'h1) * LAG_DECAY_UNIT) << c[2:0];
      default: begin
        n = {27'h0, c[4:0]};
        if (n >= 32'h1F) model = 32'h14 * LAG_NOISE_UNIT;
        else if (n >= 32'hC) model = (n - 32'hA) * LAG_NOISE_UNIT;
        else if (n >= 32'hA) model = (LAG_NOISE_UNIT / 2) << (n - 32'hA);
        else if (n >= 32'h2) model = 32'h1 << n;
      end
    endcase
  endfunction

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      axi_write(rows[i].idx, {24'h0, rows[i].wd}, resp);
      chk({30'h0, resp}, {30'h0, LAG_RESP_OKAY});
      axi_read(rows[i].idx, rd, resp);
      chk({30'h0, resp}, {30'h0, LAG_RESP_OKAY});
      chk(rd, {24'h0, rows[i].rd});
      chk(out_now(rows[i].idx), model(rows[i].idx, rows[i].wd));
    end
    // Second reset in mid-run restores every code
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({25'h0, gain_ceiling}, 32'h74);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (rst[i]) begin
      chk(out_now(rst[i].idx), model(rst[i].idx, rst[i].wd));
      axi_read(rst[i].idx, rd, resp);
      chk(rd, {24'h0, rst[i].rd});
    end
    // Unmapped place refused both ways
    axi_read(8'h00, rd, resp);
    chk(rd, 32'h0);
    chk({30'h0, resp}, {30'h0, LAG_RESP_SLVERR});
    axi_write(8'h00, 32'hFF, resp);
    chk({30'h0, resp}, {30'h0, LAG_RESP_SLVERR});
    // Tick periods and debounce while enabled
    axi_write(LAG_IDX_ATTACK, 32'h09, resp);
    axi_write(LAG_IDX_NOISE, 32'h02, resp);
    axi_write(LAG_IDX_ENABLE, 32'h80, resp);
    tick_gap(1'b0, gap);
    chk({31'h0, agc_enable}, 32'h1);
    tick_gap(1'b0, gap);
    chk(gap, model(LAG_IDX_ATTACK, 8'h09));
    tick_gap(1'b1, gap);
    tick_gap(1'b1, gap);
    chk(gap, model(LAG_IDX_DECAY, 8'h00));
    noise_below <= 1'b1;
    gap = 32'h0;
    while (noise_hold !== 1'b1 && gap < 32'h64) begin
      @(posedge aclk);
      gap++;
    end
    chk(gap, model(LAG_IDX_NOISE, 8'h02) + 32'h1);
    // Status shows ceiling, hold and enable; it refuses writes
    axi_read(LAG_IDX_STATUS, rd, resp);
    chk(rd, 32'h00007407);
    axi_write(LAG_IDX_STATUS, 32'h0, resp);
    chk({30'h0, resp}, {30'h0, LAG_RESP_SLVERR});
    axi_read(LAG_IDX_ENABLE, rd, resp);
    chk(rd, 32'h00000080);
    // Clearing enable stops attack ticks and drops the hold
    axi_write(LAG_IDX_ENABLE, 32'h0, resp);
    repeat (2) @(posedge aclk);
    chk({31'h0, noise_hold}, 32'h0);
    tick_gap(1'b0, gap);
    chk(gap, 32'h7D0);
    test_done();
  end

  // Hang guard, well above the expected run length
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 10000) begin
      fails++;
      test_done();
    end
  end
endmodule // tb_lag_config_core
